//--- hw/psc_config_top.sv
// Register side of a multiphase buck controller: shedding thresholds,
// their resistor-derived copies, hysteresis, delay and the dual source latch.
// Assumes a byte register port from the serial-bus front end, all inputs
// synchronous to CLK, and resistor codes already digitised by the analog side.
//
// How it works
// - Programmed thresholds are used only while bit 0 is set in the committed latch, else the sensed ones.
// - A programmed threshold of 0xff disables that shedding step.
// - Four read-only status registers show the resistor-derived thresholds.
// - The sensed thresholds are resampled on every rising edge of the enable input.
// - A threshold resistor level above 2 V disables that step.
// - Hysteresis counts in threshold codes, applies only when shedding, and resets to 0x08.
// - The shedding delay register sets the wait before dropping phases.
// - The delay resets to 0x14 (200 us), counts in 10 us steps, and may be rewritten at any time.
// - Any toggle of the enable input returns every setting to resistor control.
// - Apart from an enable toggle, the source changes only when the same byte has been written to both latches, in either order.
// - Latch bit 5 selects the switching frequency register over the resistor.
// - Latch bit 4 selects the load line register over the resistor.
// - Latch bit 2 selects the overcurrent limit register over the resistor.
// - Latch bit 1 defaults to 0 and selects the low power zone register when set.
// - Latch bit 0 selects the four programmed threshold registers when set.
`timescale 1ns/1ps
module psc_config_top (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic EN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire psc_pkg::psc_byte_t REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic [31:0] SENSED_TH,
  input wire logic [3:0] SENSED_OVER_2V,
  input wire psc_pkg::psc_byte_t OUTPUT_CURRENT_READING,
  output logic SWITCHING_FREQUENCY_SOURCE,
  output logic LOAD_LINE_SOURCE,
  output logic OVERCURRENT_LIMIT_SOURCE,
  output logic LOW_POWER_ZONE_SOURCE,
  output logic SHED_THRESHOLD_SELECT,
  output logic [2:0] PHASE_COUNT
);
  import psc_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  psc_byte_t prog_q [4];
  psc_byte_t sensed_q [4];
  psc_byte_t hyst_q;
  psc_byte_t delay_q;
  psc_byte_t latch_a_q;
  psc_byte_t latch_b_q;
  logic a_wr_q;
  logic b_wr_q;
  psc_byte_t sel_q;
  logic en_q;
  logic en_rise;
  logic en_toggle;
  logic commit;
  psc_byte_t rdata_d;
  logic [7:0] rdata_q;
  logic [3:0] prog_hit;
  logic [3:0] sensed_hit;

  psc_shed_if sh ();

  // ****************************************************************
  // Enable edge detection
  // ****************************************************************
  // EN arrives synchronous, so one flop is enough to see both edges
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      en_q <= 1'b0;
    end else begin
      en_q <= EN;
    end
  end
  assign en_rise = EN && !en_q;
  assign en_toggle = EN ^ en_q;

  // ****************************************************************
  // Address decode for the threshold pairs
  // ****************************************************************
  // Programmed and sensed copies sit interleaved, two offsets per step
  always_comb begin
    prog_hit = 4'h0;
    sensed_hit = 4'h0;
    for (int i = 0; i < 4; i++) begin
      prog_hit[i] = (REG_ADDR == 8'(ADDR_TH1_PROG + 2 * i));
      sensed_hit[i] = (REG_ADDR == 8'(ADDR_TH1_SENSED + 2 * i));
    end
  end

  // ****************************************************************
  // Per-step threshold registers
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_step
      // Programmed threshold, writable at any time
      always_ff @(posedge CLK) begin
        if (!RESET_N) begin
          prog_q[g] <= TH_PROG_RESET;
        end else if (REG_WR && prog_hit[g]) begin
          prog_q[g] <= REG_WDATA;
        end
      end

      // Resistor copy, taken only on the rising enable edge
      always_ff @(posedge CLK) begin
        if (!RESET_N) begin
          sensed_q[g] <= TH_DISABLED;
        end else if (en_rise) begin
          if (SENSED_OVER_2V[g]) begin
            sensed_q[g] <= TH_DISABLED;
          end else begin
            sensed_q[g] <= SENSED_TH[8*g +: 8];
          end
        end
      end

      // Source choice and disable code per step
      assign sh.th[g] = sel_q[BIT_TH] ? prog_q[g] : sensed_q[g];
      assign sh.th_en[g] = (sh.th[g] != TH_DISABLED);
    end
  endgenerate

  // ****************************************************************
  // Hysteresis and delay
  // ****************************************************************
  // Hysteresis is a plain byte; its meaning lives in the engine
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      hyst_q <= HYST_RESET;
    end else if (REG_WR && (REG_ADDR == ADDR_HYST)) begin
      hyst_q <= REG_WDATA;
    end
  end

  // Delay may change mid-wait; the engine compares live
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      delay_q <= DELAY_RESET;
    end else if (REG_WR && (REG_ADDR == ADDR_DELAY)) begin
      delay_q <= REG_WDATA;
    end
  end

  // ****************************************************************
  // Source latches
  // ****************************************************************
  // Latch A byte; its written flag is kept below with B's
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      latch_a_q <= LATCH_RESET;
    end else if (REG_WR && (REG_ADDR == ADDR_LATCH_A)) begin
      latch_a_q <= REG_WDATA;
    end
  end

  // Latch B byte
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      latch_b_q <= LATCH_RESET;
    end else if (REG_WR && (REG_ADDR == ADDR_LATCH_B)) begin
      latch_b_q <= REG_WDATA;
    end
  end

  // Written flags; a fresh write in a commit or toggle cycle is kept, not lost
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      a_wr_q <= 1'b0;
      b_wr_q <= 1'b0;
    end else begin
      if (REG_WR && (REG_ADDR == ADDR_LATCH_A)) begin
        a_wr_q <= 1'b1;
      end else if (commit || en_toggle) begin
        a_wr_q <= 1'b0;
      end
      if (REG_WR && (REG_ADDR == ADDR_LATCH_B)) begin
        b_wr_q <= 1'b1;
      end else if (commit || en_toggle) begin
        b_wr_q <= 1'b0;
      end
    end
  end

  // Both written and equal, order free
  assign commit = a_wr_q && b_wr_q && (latch_a_q == latch_b_q);

  // Committed source selection; an enable toggle outranks a commit
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sel_q <= LATCH_RESET;
    end else if (en_toggle) begin
      sel_q <= LATCH_RESET;
    end else if (commit) begin
      sel_q <= latch_a_q & LATCH_MASK;
    end
  end

  // ****************************************************************
  // Source outputs
  // ****************************************************************
  // The frequency, load line, overcurrent and zone registers live elsewhere; only the choice leaves here
  assign SWITCHING_FREQUENCY_SOURCE = sel_q[BIT_FSW];
  assign LOAD_LINE_SOURCE = sel_q[BIT_LL];
  assign OVERCURRENT_LIMIT_SOURCE = sel_q[BIT_OCP];
  assign LOW_POWER_ZONE_SOURCE = sel_q[BIT_LPZ];
  assign SHED_THRESHOLD_SELECT = sel_q[BIT_TH];

  // ****************************************************************
  // Shedding engine
  // ****************************************************************
  assign sh.hyst = hyst_q;
  assign sh.delay = delay_q;
  assign sh.iout = OUTPUT_CURRENT_READING;

  psc_shed_engine u_engine (
    .clk(CLK),
    .rst_n(RESET_N),
    .sh(sh.eng)
  );
  assign PHASE_COUNT = sh.phases;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Latches read back what was written, not what is committed
  always_comb begin
    rdata_d = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (prog_hit[i]) begin
        rdata_d = prog_q[i];
      end
      if (sensed_hit[i]) begin
        rdata_d = sensed_q[i];
      end
    end
    case (REG_ADDR)
      ADDR_HYST: rdata_d = hyst_q;
      ADDR_DELAY: rdata_d = delay_q;
      ADDR_LATCH_A: rdata_d = latch_a_q;
      ADDR_LATCH_B: rdata_d = latch_b_q;
      default: ;
    endcase
  end

  // Registered so the serial shifter sees a stable byte
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      rdata_q <= rdata_d;
    end
  end
  assign REG_RDATA = rdata_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_th_source: assert property (@(posedge CLK) disable iff (!RESET_N)
    sh.th[0] == (SHED_THRESHOLD_SELECT ? prog_q[0] : sensed_q[0]))
    else $error("Threshold one taken from the wrong source");
  a_prog_off: assert property (@(posedge CLK) disable iff (!RESET_N)
    (SHED_THRESHOLD_SELECT && prog_q[1] == 8'hff) |-> !sh.th_en[1])
    else $error("Threshold code 0xff did not disable the step");
  a_sample_rise: assert property (@(posedge CLK) disable iff (!RESET_N)
    (EN && !en_q && !SENSED_OVER_2V[0]) |=> (sensed_q[0] == $past(SENSED_TH[7:0])))
    else $error("Sensed threshold not captured on enable rise");
  a_sample_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    !(EN && !en_q) |=> $stable(sensed_q[2]))
    else $error("Sensed threshold moved without an enable rise");
  a_over_2v: assert property (@(posedge CLK) disable iff (!RESET_N)
    (EN && !en_q && SENSED_OVER_2V[3]) |=> (sensed_q[3] == 8'hff && !sh.th_en[3] || SHED_THRESHOLD_SELECT))
    else $error("Over-level threshold input not disabled");
  a_reset_vals: assert property (@(posedge CLK)
    $rose(RESET_N) |-> (hyst_q == 8'h08 && delay_q == 8'h14 && sel_q == 8'h00))
    else $error("Hysteresis, delay or latch reset value wrong");
  a_toggle_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
    (EN != en_q) |=> (sel_q == 8'h00)[*2])
    else $error("Enable toggle did not restore resistor control");
  a_latch_agree: assert property (@(posedge CLK) disable iff (!RESET_N)
    (sel_q != $past(sel_q)) |-> ($past(latch_a_q == latch_b_q && a_wr_q && b_wr_q) || $past(EN != en_q)))
    else $error("Source changed without matching latch writes");
  a_source_map: assert property (@(posedge CLK) disable iff (!RESET_N)
    $past(commit && !en_toggle) |-> ({SWITCHING_FREQUENCY_SOURCE, LOAD_LINE_SOURCE, OVERCURRENT_LIMIT_SOURCE,
      LOW_POWER_ZONE_SOURCE} == {$past(latch_a_q[5]), $past(latch_a_q[4]), $past(latch_a_q[2]),
      $past(latch_a_q[1])}))
    else $error("Source outputs do not follow the committed byte");

  c_en_rise: cover property (@(posedge CLK) disable iff (!RESET_N) EN && !en_q);
  c_commit: cover property (@(posedge CLK) disable iff (!RESET_N) commit && latch_a_q[BIT_TH]);
  c_phase_up: cover property (@(posedge CLK) disable iff (!RESET_N) PHASE_COUNT > $past(PHASE_COUNT));
  c_phase_down: cover property (@(posedge CLK) disable iff (!RESET_N) PHASE_COUNT < $past(PHASE_COUNT));
endmodule

//--- hw/psc_shed_engine.sv
// Phase-count decision: adds phases at once, sheds after a delay.
// Assumes thresholds ascend from step one to step four.
`timescale 1ns/1ps
module psc_shed_engine (
  input wire logic clk,
  input wire logic rst_n,
  psc_shed_if.eng sh
);
  import psc_pkg::*;

  logic [9:0] div_q;
  logic tick;
  logic [7:0] wait_q;
  logic [2:0] phase_q;
  logic [2:0] up_cnt;
  logic [2:0] dn_cnt;
  logic shed_cond;
  logic drop;

  // ****************************************************************
  // 10 us delay tick
  // ****************************************************************
  // One divider keeps the delay counter eight bits wide; it restarts with
  // every wait, so the first 10 us step is a whole one and never a fraction
  always_ff @(posedge clk) begin
    if (!rst_n || tick || !shed_cond || drop) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end
  assign tick = (div_q == 10'(TICK_CYCLES - 1));

  // Targets for rising and for falling load, hysteresis on the fall only
  always_comb begin
    up_cnt = PHASES_MIN;
    dn_cnt = PHASES_MIN;
    for (int i = 0; i < 4; i++) begin
      if (sh.th_en[i] && (sh.iout > sh.th[i])) begin
        up_cnt = up_cnt + 3'h1;
      end
      if (sh.th_en[i] && (({1'b0, sh.iout} + {1'b0, sh.hyst}) > {1'b0, sh.th[i]})) begin
        dn_cnt = dn_cnt + 3'h1;
      end
    end
    // Four enabled steps would otherwise ask for a fifth phase
    if (up_cnt > PHASES_MAX) begin
      up_cnt = PHASES_MAX;
    end
    if (dn_cnt > PHASES_MAX) begin
      dn_cnt = PHASES_MAX;
    end
  end

  // Shedding is pending while no step asks for more phases and the hysteresis target is below the count
  assign shed_cond = (up_cnt <= phase_q) && (dn_cnt < phase_q);
  assign drop = shed_cond && (wait_q >= sh.delay);

  // Phase count and shed wait
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= PHASES_MAX;
      wait_q <= 8'h00;
    end else if (up_cnt > phase_q) begin
      phase_q <= up_cnt;
      wait_q <= 8'h00;
    end else if (dn_cnt < phase_q) begin
      if (wait_q >= sh.delay) begin
        phase_q <= dn_cnt;
        wait_q <= 8'h00;
      end else if (tick) begin
        wait_q <= wait_q + 8'h01;
      end
    end else begin
      wait_q <= 8'h00; // Any recovery restarts the wait
    end
  end
  assign sh.phases = phase_q;

  a_shed_waits: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q < $past(phase_q)) |-> ($past(wait_q) >= $past(sh.delay)))
    else $error("Phases dropped before the shed delay ran out");
  a_add_at_once: assert property (@(posedge clk) disable iff (!rst_n)
    (up_cnt > phase_q) |=> (phase_q == $past(up_cnt)))
    else $error("Phases not added on the next cycle");
  a_phase_range: assert property (@(posedge clk) disable iff (!rst_n)
    (phase_q >= PHASES_MIN) && (phase_q <= PHASES_MAX))
    else $error("Phase count left the range one to four");
endmodule

//--- shared/psc_pkg.sv
// Constants shared by the phase-shedding configuration block.
// Assumes a 100 MHz system clock and byte-wide register access.
package psc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_TH1_PROG = 8'h3a;
  localparam logic [7:0] ADDR_TH1_SENSED = 8'h3b;
  localparam logic [7:0] ADDR_TH2_PROG = 8'h3c;
  localparam logic [7:0] ADDR_TH2_SENSED = 8'h3d;
  localparam logic [7:0] ADDR_TH3_PROG = 8'h3e;
  localparam logic [7:0] ADDR_TH3_SENSED = 8'h3f;
  localparam logic [7:0] ADDR_TH4_PROG = 8'h40;
  localparam logic [7:0] ADDR_TH4_SENSED = 8'h41;
  localparam logic [7:0] ADDR_HYST = 8'h44;
  localparam logic [7:0] ADDR_DELAY = 8'h45;
  localparam logic [7:0] ADDR_LATCH_A = 8'h46;
  localparam logic [7:0] ADDR_LATCH_B = 8'h47;

  // ****************************************************************
  // Latch bit positions and reset values
  // ****************************************************************
  localparam int BIT_FSW = 5;
  localparam int BIT_LL = 4;
  localparam int BIT_OCP = 2;
  localparam int BIT_LPZ = 1;
  localparam int BIT_TH = 0;
  localparam logic [7:0] LATCH_MASK = 8'h37;
  localparam logic [7:0] HYST_RESET = 8'h08;
  localparam logic [7:0] DELAY_RESET = 8'h14;
  localparam logic [7:0] TH_PROG_RESET = 8'hff;
  localparam logic [7:0] TH_DISABLED = 8'hff;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [2:0] PHASES_MAX = 3'h4;
  localparam logic [2:0] PHASES_MIN = 3'h1;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int DELAY_STEP_US = 10;
  localparam int TICK_CYCLES = DELAY_STEP_US * CLK_MHZ;

  typedef logic [7:0] psc_byte_t;

endpackage

//--- shared/psc_shed_if.sv
// Carrier between the register side and the shedding engine.
// Both ends share one clock; no crossing here.
`timescale 1ns/1ps
interface psc_shed_if;
  import psc_pkg::*;
  psc_byte_t th [4];
  logic [3:0] th_en;
  psc_byte_t hyst;
  psc_byte_t delay;
  psc_byte_t iout;
  logic [2:0] phases;
  modport ctl (output th, output th_en, output hyst, output delay, output iout, input phases);
  modport eng (input th, input th_en, input hyst, input delay, input iout, output phases);
endinterface

//--- tb/psc_config_top_tb_top.sv
// Self-checking bench for the shedding configuration block.
// Assumes the host model drives the register port; all other inputs come from here.
`timescale 1ns/1ps
module psc_config_top_tb_top;
  import psc_pkg::*;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic [31:0] sensed_th = 32'h0;
  logic [3:0] over_2v = 4'h0;
  psc_byte_t iout = 8'h00;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  psc_byte_t reg_wdata;
  logic [7:0] reg_rdata;
  logic sw_src;
  logic ll_src;
  logic oc_src;
  logic lpz_src;
  logic th_sel;
  logic [2:0] phases;
  logic [4:0] srcs;
  psc_byte_t rdv;
  int failures = 0;
  int n_checks = 0;

  // Source flags in latch bit order 5, 4, 2, 1, 0
  assign srcs = {sw_src, ll_src, oc_src, lpz_src, th_sel};
  always #5 clk = ~clk;

  psc_config_top i_psc_config_top (
    .CLK(clk),
    .RESET_N(rst_n),
    .EN(en),
    .REG_WR(reg_wr),
    .REG_RD(reg_rd),
    .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata),
    .SENSED_TH(sensed_th),
    .SENSED_OVER_2V(over_2v),
    .OUTPUT_CURRENT_READING(iout),
    .SWITCHING_FREQUENCY_SOURCE(sw_src),
    .LOAD_LINE_SOURCE(ll_src),
    .OVERCURRENT_LIMIT_SOURCE(oc_src),
    .LOW_POWER_ZONE_SOURCE(lpz_src),
    .SHED_THRESHOLD_SELECT(th_sel),
    .PHASE_COUNT(phases)
  );

  psc_host_model i_psc_host_model (
    .clk(clk),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Reset value per offset; unmapped offsets read zero
  function automatic psc_byte_t rst_val(input logic [7:0] a);
    case (a)
      8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41: return 8'hff;
      8'h44: return 8'h08;
      8'h45: return 8'h14;
      default: return 8'h00;
    endcase
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    i_psc_host_model.rd(a, rdv);
    chk(rdv, exp, "register read");
  endtask

  // Let n edges pass, then look once their updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait: a miss is a mismatch and ends the run
  task automatic wait_phase(input logic [2:0] exp, input int max);
    for (int k = 0; k < max && phases !== exp; k++) begin
      cyc(1);
    end
    chk({5'h0, phases}, {5'h0, exp}, "phase count wait");
    if (phases !== exp) begin
      conclude();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  // Shedding steps last thousands of cycles, so the delay is cut to one tick early
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk({5'h0, phases}, 8'h04, "reset phase count");
    chk({3'h0, srcs}, 8'h00, "reset sources");
    for (int a = 8'h38; a <= 8'h48; a++) begin
      rdchk(a[7:0], rst_val(a[7:0]));
    end
    i_psc_host_model.wr(ADDR_DELAY, 8'h01);
    rdchk(ADDR_DELAY, 8'h01);
    i_psc_host_model.wr(ADDR_TH1_SENSED, 8'h12);
    rdchk(ADDR_TH1_SENSED, 8'hff);
    // Step four sits above 2 V
    @(posedge clk);
    sensed_th <= 32'h34302010;
    over_2v <= 4'b1000;
    en <= 1'b1;
    cyc(2);
    rdchk(ADDR_TH1_SENSED, 8'h10);
    rdchk(ADDR_TH2_SENSED, 8'h20);
    rdchk(ADDR_TH3_SENSED, 8'h30);
    rdchk(ADDR_TH4_SENSED, 8'hff);
    // Unequal bytes must not commit
    i_psc_host_model.wr(ADDR_LATCH_A, 8'h37);
    i_psc_host_model.wr(ADDR_LATCH_B, 8'h35);
    cyc(3);
    chk({3'h0, srcs}, 8'h00, "unequal latches");
    i_psc_host_model.wr(ADDR_LATCH_B, 8'h37);
    cyc(2);
    chk({3'h0, srcs}, 8'h1f, "register sources");
    @(posedge clk);
    en <= 1'b0;
    sensed_th <= 32'h34302018;
    cyc(2);
    chk({3'h0, srcs}, 8'h00, "sources after enable fall");
    // Distinct bits, A first; reserved bit 3 must reach no source
    i_psc_host_model.pair(1'b0, 8'h1a);
    cyc(2);
    chk({3'h0, srcs}, 8'h0a, "load line and zone sources");
    @(posedge clk);
    en <= 1'b1;
    cyc(2);
    chk({3'h0, srcs}, 8'h00, "sources after enable rise");
    rdchk(ADDR_TH1_SENSED, 8'h18);
    // Resistor thresholds decide the phase count
    @(posedge clk);
    iout <= 8'h00;
    wait_phase(3'h1, 3000);
    @(posedge clk);
    iout <= 8'h38;
    cyc(2);
    chk({5'h0, phases}, 8'h04, "sensed thresholds add phases");
    // All programmed steps disabled: near full scale nothing holds phases up
    @(posedge clk);
    iout <= 8'hfc;
    i_psc_host_model.pair(1'b1, 8'h01);
    cyc(2);
    chk({3'h0, srcs}, 8'h01, "threshold source only");
    wait_phase(3'h1, 2200);
    i_psc_host_model.wr(ADDR_TH1_PROG, 8'h20);
    cyc(2);
    chk({5'h0, phases}, 8'h02, "programmed step adds phase");
    @(posedge clk);
    iout <= 8'h1c;
    cyc(2500);
    chk({5'h0, phases}, 8'h02, "hysteresis band holds");
    @(posedge clk);
    iout <= 8'h10;
    cyc(900);
    chk({5'h0, phases}, 8'h02, "shed delay not yet over");
    wait_phase(3'h1, 1200);
    conclude();
  end
endmodule

//--- tb/psc_host_model.sv
// Host model for the byte register port of the shedding configuration block.
// Assumes one clock, strobes sampled on its rising edge, read data one edge later.
`timescale 1ns/1ps
module psc_host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output psc_pkg::psc_byte_t reg_wdata,
  input wire logic [7:0] reg_rdata
);
  import psc_pkg::*;

  // ****************************************************************
  // Bus access tasks
  // ****************************************************************
  // Idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One-cycle write; released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] addr, input psc_byte_t data);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask

  // One-cycle read; the byte is taken one edge after the strobe edge
  task automatic rd(input logic [7:0] addr, output psc_byte_t data);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    @(posedge clk);
    #1;
    data = reg_rdata;
  endtask

  // Same byte to both latches, either order
  task automatic pair(input logic b_first, input psc_byte_t data);
    if (b_first) begin
      wr(ADDR_LATCH_B, data);
      wr(ADDR_LATCH_A, data);
    end else begin
      wr(ADDR_LATCH_A, data);
      wr(ADDR_LATCH_B, data);
    end
  endtask
endmodule
